// ==== pmd_pkg.sv ====
// Constants, types and the edge sensing helper for the page-mode strobe block.
// Assumes one core clock that runs far faster than the processor clock.

package pmd_pkg;
	localparam int PAGE_ADDR_W = 15;
	localparam int HIT_CNT_W = 16;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] HITS_OFS = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FLUSH_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		PMD_IDLE = 3'b000,
		PMD_PRECH = 3'b001,
		PMD_ROW = 3'b010,
		PMD_ACT = 3'b011,
		PMD_END = 3'b100
	} pmd_state_t;

	typedef enum logic [1:0] {
		PMD_HIT = 2'b00,
		PMD_MISS = 2'b01,
		PMD_ZW = 2'b10,
		PMD_ONE = 2'b11
	} pmd_ctype_t;
endpackage

`timescale 1ns/1ps

module pmd_edge_sense (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Processor clock and strobes
	input wire logic i_processor_clock,
	input wire logic i_memory_read_strobe_n,
	input wire logic i_memory_write_strobe_n,
	// Edge pulses and strobe levels
	output logic o_rise,
	output logic o_fall,
	output logic o_rd_n,
	output logic o_wr_n
);
	typedef struct packed {
		logic clk_now;
		logic clk_prev;
		logic rd_n;
		logic wr_n;
	} pmd_sense_t;

	pmd_sense_t st_r;
	pmd_sense_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.clk_now = i_processor_clock;
		st_nxt.clk_prev = st_r.clk_now;
		st_nxt.rd_n = i_memory_read_strobe_n;
		st_nxt.wr_n = i_memory_write_strobe_n;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '{clk_now: 1'b0, clk_prev: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Strobe levels are the ones seen together with the edge pulse
	assign o_rise = st_r.clk_now & ~st_r.clk_prev;
	assign o_fall = ~st_r.clk_now & st_r.clk_prev;
	assign o_rd_n = st_r.rd_n;
	assign o_wr_n = st_r.wr_n;
endmodule

// ==== pmd_strobe_ctrl.sv ====
// Row and column strobe timing engine with its register slave.
// Assumes the processor clock and strobes are synchronous to the core clock.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module pmd_strobe_ctrl #(
	parameter int PAGE_W = pmd_pkg::PAGE_ADDR_W
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Processor side
	input wire logic i_processor_clock,
	input wire logic i_memory_read_strobe_n,
	input wire logic i_memory_write_strobe_n,
	input wire logic i_cpu_hold_ack,
	input wire logic [PAGE_W-1:0] i_page_addr,
	input wire logic i_byte_high_n,
	input wire logic i_xbyte_high_n,
	input wire logic i_addr0,
	input wire logic i_xaddr0,
	input wire logic [1:0] i_row_select,
	input wire logic [1:0] i_col_select,
	// Straps
	input wire logic i_page_mode_select_n,
	input wire logic i_bank_group_select,
	input wire logic i_read_wait_select,
	input wire logic i_write_wait_select,
	// Memory side
	output logic [3:0] o_row_strobe_n,
	output logic o_row_column_mux_select,
	output logic [3:0] o_column_strobe_n,
	output logic o_zero_wait_indicator_n_o,
	output logic o_zero_wait_indicator_n_oe,
	output logic o_iochrdy_o,
	output logic o_iochrdy_oe,
	// Avalon-MM slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);
	typedef struct packed {
		pmd_pkg::pmd_state_t state;
		pmd_pkg::pmd_ctype_t ctype;
		logic cas_on;
		logic [3:0] cas_en;
		logic [PAGE_W-1:0] page;
		logic page_valid;
		logic row_n;
		logic mux;
		logic [3:0] cas_n;
		logic zw_oe;
		logic rdy_o;
		logic rdy_oe;
		logic en;
		logic flush;
		logic [pmd_pkg::HIT_CNT_W-1:0] hits;
		logic avs_wait;
		logic [31:0] rdata;
	} pmd_ctrl_t;

	pmd_ctrl_t st_r;
	pmd_ctrl_t st_nxt;
	logic rise;
	logic fall;
	logic rd_n;
	logic wr_n;
	logic is_write;
	logic page_mode;
	logic wait_sel;
	logic cas_hi;
	logic cas_lo;
	logic en_c0;
	logic en_c1;
	logic [3:0] cas_dec;
	logic [31:0] rd_val;

	pmd_edge_sense u_sense (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_processor_clock(i_processor_clock),
		.i_memory_read_strobe_n(i_memory_read_strobe_n),
		.i_memory_write_strobe_n(i_memory_write_strobe_n),
		.o_rise(rise),
		.o_fall(fall),
		.o_rd_n(rd_n),
		.o_wr_n(wr_n)
	);

	// Straps are read live; they must not move while the block runs
	assign is_write = ~wr_n;
	assign page_mode = ~i_page_mode_select_n & ~i_cpu_hold_ack;
	assign wait_sel = is_write ? i_write_wait_select : i_read_wait_select;
	assign cas_hi = i_cpu_hold_ack ? ~i_xbyte_high_n : ~i_byte_high_n;
	assign cas_lo = i_cpu_hold_ack ? ~i_xaddr0 : ~i_addr0;
	assign en_c1 = i_col_select[1] &
		(i_bank_group_select ? i_row_select[1] : i_row_select[0]);
	assign en_c0 = i_col_select[0] &
		(i_bank_group_select ? i_row_select[0] : i_row_select[1]);
	assign cas_dec = {en_c1 & cas_hi, en_c1 & cas_lo,
		en_c0 & cas_hi, en_c0 & cas_lo};

	always_comb begin
		rd_val = 32'h0000_0000;
		case (i_avs_address)
			pmd_pkg::CTRL_OFS: rd_val = {30'h0000_0000, st_r.flush, st_r.en};
			pmd_pkg::STAT_OFS: rd_val = {20'h0_0000, st_r.page_valid,
				st_r.row_n, st_r.mux, st_r.zw_oe, st_r.rdy_oe, st_r.cas_on,
				st_r.ctype, 1'b0, st_r.state};
			pmd_pkg::HITS_OFS: rd_val = {16'h0000, st_r.hits};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r.state)
			pmd_pkg::PMD_IDLE: begin
				if (fall && !st_r.en) begin
					st_nxt.row_n = 1'b1;
					st_nxt.mux = 1'b0;
					st_nxt.page_valid = 1'b0;
				end else if (fall && (!rd_n || !wr_n)) begin
					st_nxt.cas_en = cas_dec;
					st_nxt.cas_on = 1'b0;
					if (page_mode) begin
						if (!is_write && st_r.page_valid && !st_r.flush &&
							i_page_addr == st_r.page) begin
							st_nxt.ctype = pmd_pkg::PMD_HIT;
							st_nxt.zw_oe = 1'b1;
							st_nxt.hits = st_r.hits + 1'b1;
							st_nxt.state = pmd_pkg::PMD_ACT;
						end else begin
							// Miss or write: precharge and hold off the CPU
							st_nxt.ctype = pmd_pkg::PMD_MISS;
							st_nxt.flush = 1'b0;
							st_nxt.row_n = 1'b1;
							st_nxt.rdy_o = 1'b0;
							st_nxt.rdy_oe = 1'b1;
							st_nxt.state = pmd_pkg::PMD_PRECH;
						end
					end else if (!wait_sel) begin
						st_nxt.ctype = pmd_pkg::PMD_ZW;
						st_nxt.row_n = 1'b0;
						st_nxt.mux = 1'b1;
						st_nxt.state = pmd_pkg::PMD_ACT;
					end else begin
						st_nxt.ctype = pmd_pkg::PMD_ONE;
						st_nxt.row_n = 1'b0;
						st_nxt.state = pmd_pkg::PMD_ROW;
					end
				end
			end
			pmd_pkg::PMD_PRECH: begin
				if (rise) begin
					st_nxt.mux = 1'b0;
				end else if (fall) begin
					st_nxt.row_n = 1'b0;
					st_nxt.state = pmd_pkg::PMD_ROW;
				end
			end
			pmd_pkg::PMD_ROW: begin
				if (rise) begin
					st_nxt.mux = 1'b1;
					st_nxt.state = pmd_pkg::PMD_ACT;
				end
			end
			pmd_pkg::PMD_ACT: begin
				if (rise && !st_r.cas_on && st_r.ctype != pmd_pkg::PMD_ZW) begin
					st_nxt.cas_n = ~st_r.cas_en;
					st_nxt.cas_on = 1'b1;
				end else if (rise && st_r.rdy_oe && st_r.rdy_o) begin
					st_nxt.rdy_oe = 1'b0;
					st_nxt.rdy_o = 1'b0;
				end else if (fall && !st_r.cas_on &&
					st_r.ctype == pmd_pkg::PMD_ZW) begin
					st_nxt.cas_n = ~st_r.cas_en;
					st_nxt.cas_on = 1'b1;
				end else if (fall && st_r.cas_on && st_r.rdy_oe &&
					!st_r.rdy_o) begin
					st_nxt.rdy_o = 1'b1;
				end else if (fall && st_r.cas_on && rd_n && wr_n) begin
					st_nxt.cas_n = 4'hF;
					st_nxt.cas_on = 1'b0;
					if (st_r.ctype == pmd_pkg::PMD_HIT ||
						st_r.ctype == pmd_pkg::PMD_MISS) begin
						// Row stays open so the next read can hit
						st_nxt.page = i_page_addr;
						st_nxt.page_valid = 1'b1;
						st_nxt.state = pmd_pkg::PMD_END;
					end else if (st_r.ctype == pmd_pkg::PMD_ZW) begin
						st_nxt.row_n = 1'b1;
						st_nxt.mux = 1'b0;
						st_nxt.state = pmd_pkg::PMD_IDLE;
					end else begin
						st_nxt.row_n = 1'b1;
						st_nxt.state = pmd_pkg::PMD_END;
					end
				end
			end
			pmd_pkg::PMD_END: begin
				if (rise) begin
					if (st_r.ctype == pmd_pkg::PMD_ONE) begin
						st_nxt.mux = 1'b0;
					end
					st_nxt.zw_oe = 1'b0;
					if (st_r.rdy_oe && st_r.rdy_o) begin
						st_nxt.rdy_oe = 1'b0;
						st_nxt.rdy_o = 1'b0;
					end
					st_nxt.state = pmd_pkg::PMD_IDLE;
				end
			end
			default: st_nxt.state = pmd_pkg::PMD_IDLE;
		endcase

		// One wait cycle on every access keeps the read path registered
		st_nxt.avs_wait = 1'b1;
		if ((i_avs_read || i_avs_write) && st_r.avs_wait) begin
			st_nxt.avs_wait = 1'b0;
			st_nxt.rdata = i_avs_read ? rd_val : 32'h0000_0000;
		end
		// Placed last so a flush write beats the engine clearing it
		if (i_avs_write && !st_r.avs_wait && i_avs_byteenable[0] &&
			i_avs_address == pmd_pkg::CTRL_OFS) begin
			st_nxt.en = i_avs_writedata[pmd_pkg::CTRL_EN_BIT];
			if (i_avs_writedata[pmd_pkg::CTRL_FLUSH_BIT]) begin
				st_nxt.flush = 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '{state: pmd_pkg::PMD_IDLE, ctype: pmd_pkg::PMD_ONE,
				cas_on: 1'b0, cas_en: 4'h0, page: '0, page_valid: 1'b0,
				row_n: 1'b1, mux: 1'b0, cas_n: 4'hF, zw_oe: 1'b0,
				rdy_o: 1'b0, rdy_oe: 1'b0, en: pmd_pkg::CTRL_EN_RST,
				flush: 1'b0, hits: '0, avs_wait: 1'b1,
				rdata: pmd_pkg::RDATA_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_row_strobe_n = {4{st_r.row_n}};
	assign o_row_column_mux_select = st_r.mux;
	assign o_column_strobe_n = st_r.cas_n;
	// Open drain: only ever pulls low, the pull-up does the rest
	assign o_zero_wait_indicator_n_o = st_r.rdy_o & 1'b0;
	assign o_zero_wait_indicator_n_oe = st_r.zw_oe;
	assign o_iochrdy_o = st_r.rdy_o;
	assign o_iochrdy_oe = st_r.rdy_oe;
	assign o_avs_readdata = st_r.rdata;
	assign o_avs_waitrequest = st_r.avs_wait;

	AST_START_ON_FALL: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st_r.state == pmd_pkg::PMD_IDLE &&
		st_nxt.state != pmd_pkg::PMD_IDLE) |-> fall && (!rd_n || !wr_n))
		else $error("cycle started without a sampled strobe");
	AST_MUX_ON_RISE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		($changed(st_r.mux) && st_r.ctype != pmd_pkg::PMD_ZW &&
		$past(st_r.state) != pmd_pkg::PMD_IDLE) |-> $past(rise))
		else $error("mux select moved off a rising edge");
	AST_MUX_ON_FALL: assert property (@(posedge i_core_clk) disable iff (i_rst)
		($changed(st_r.mux) && st_r.ctype == pmd_pkg::PMD_ZW) |->
		$past(fall) && (st_r.mux == ~st_r.row_n))
		else $error("zero-wait mux select not with row strobe on fall");
	AST_CAS_OFF_FALL: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(|(st_r.cas_n & ~$past(st_r.cas_n))) |-> $past(fall))
		else $error("column strobe released off a falling edge");
	AST_CAS_ON_RISE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		((|(~st_r.cas_n & $past(st_r.cas_n))) &&
		st_r.ctype != pmd_pkg::PMD_ZW) |-> $past(rise) && st_r.mux)
		else $error("column strobe asserted off a rising edge");
	AST_CAS_ON_FALL: assert property (@(posedge i_core_clk) disable iff (i_rst)
		((|(~st_r.cas_n & $past(st_r.cas_n))) &&
		st_r.ctype == pmd_pkg::PMD_ZW) |-> $past(fall))
		else $error("zero-wait column strobe not on falling edge");
	AST_ZW_RELEASE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(st_r.zw_oe) |-> $past(rise) && $past(st_r.state) ==
		pmd_pkg::PMD_END)
		else $error("zero-wait indicator released off a rising edge");
	AST_RDY_TRISTATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(st_r.rdy_oe) |-> $past(rise) && $past(st_r.rdy_o))
		else $error("ready released without high drive or rising edge");
	AST_RDY_HIGH_FALL: assert property (@(posedge i_core_clk) disable iff (i_rst)
		($rose(st_r.rdy_o) && st_r.rdy_oe) |-> $past(fall))
		else $error("ready driven high off a falling edge");
	AST_HIT_ONLY_ZW: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(st_r.zw_oe) |-> st_r.ctype == pmd_pkg::PMD_HIT && !st_r.rdy_oe)
		else $error("zero-wait indicator pulled outside a page hit");
	AST_MISS_PRECHARGE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st_r.state == pmd_pkg::PMD_PRECH) |-> st_r.row_n && st_r.rdy_oe &&
		!st_r.rdy_o && !i_cpu_hold_ack)
		else $error("miss without precharge and ready low");
endmodule

// ==== pmd_host_model.sv ====
// Host model: makes the processor clock and resolves the wait lines.
// Assumes one core clock; each processor clock phase lasts HALF core cycles.
`timescale 1ns/1ps

module pmd_host_model #(
	parameter int HALF = 8
) (
	// Core clock
	input wire logic i_core_clk,
	// Wait outputs of the block
	input wire logic i_zw_o,
	input wire logic i_zw_oe,
	input wire logic i_rdy_o,
	input wire logic i_rdy_oe,
	// Processor clock and resolved lines
	output logic o_processor_clock,
	output logic o_zw_line,
	output logic o_rdy_line
);
	int cnt = 0;

	initial o_processor_clock = 1'b0;

	// Long phases keep every output move inside the phase that caused it
	always @(posedge i_core_clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1)
			o_processor_clock <= ~o_processor_clock;
	end

	// Pull-ups hold both lines high once released
	assign o_zw_line = i_zw_oe ? i_zw_o : 1'b1;
	assign o_rdy_line = i_rdy_oe ? i_rdy_o : 1'b1;
endmodule

// ==== page_mode_dram_edge_timing_bench.sv ====
// Self-checking bench for the strobe timing block.
// Assumes the host model's slow processor clock; the bench drives the rest.
`timescale 1ns/1ps

module page_mode_dram_edge_timing_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pclk, zw_line, rdy_line, mux, zw_o, zw_oe, rdy_o, rdy_oe, wrq;
	logic rd_n = 1'b1, wr_n = 1'b1, hold = 1'b0, avr = 1'b0, avw = 1'b0;
	logic page_n = 1'b0, grp = 1'b1, rwt = 1'b1, wwt = 1'b1;
	logic [14:0] page = 15'h0000;
	logic [3:0] ras_n, cas_n;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, rd;
	int n_errors = 0, tests_run = 0, n_rdy = 0, n_zw = 0;
	logic on_rise = 1'b1, pclk_q = 1'b0, mux_q = 1'b0;
	logic roe_q = 1'b0, ro_q = 1'b0, zoe_q = 1'b0;
	logic [3:0] cas_q = 4'hF, exp_cas = 4'hC, ras_q = 4'hF;

	initial forever #2.5 clk = ~clk;

	pmd_host_model host_u (.i_core_clk(clk), .i_zw_o(zw_o), .i_zw_oe(zw_oe),
		.i_rdy_o(rdy_o), .i_rdy_oe(rdy_oe), .o_processor_clock(pclk),
		.o_zw_line(zw_line), .o_rdy_line(rdy_line));

	pmd_strobe_ctrl dut_u (.i_core_clk(clk), .i_rst(rst),
		.i_processor_clock(pclk), .i_memory_read_strobe_n(rd_n),
		.i_memory_write_strobe_n(wr_n), .i_cpu_hold_ack(hold),
		.i_page_addr(page), .i_byte_high_n(hold), .i_xbyte_high_n(1'b0),
		.i_addr0(1'b0), .i_xaddr0(hold), .i_row_select(2'b11),
		.i_col_select(2'b01), .i_page_mode_select_n(page_n),
		.i_bank_group_select(grp), .i_read_wait_select(rwt),
		.i_write_wait_select(wwt), .o_row_strobe_n(ras_n),
		.o_row_column_mux_select(mux), .o_column_strobe_n(cas_n),
		.o_zero_wait_indicator_n_o(zw_o), .o_zero_wait_indicator_n_oe(zw_oe),
		.o_iochrdy_o(rdy_o), .o_iochrdy_oe(rdy_oe), .i_avs_address(addr),
		.i_avs_read(avr), .i_avs_write(avw), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wrq));

	task automatic chk_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_nib(input string nm, input logic [3:0] e,
			input logic [3:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Edge monitor: pclk holds its level for 8 core cycles after each edge
	always @(posedge clk) begin
		pclk_q <= pclk;
		cas_q <= cas_n;
		mux_q <= mux;
		roe_q <= rdy_oe;
		ro_q <= rdy_o;
		zoe_q <= zw_oe;
		ras_q <= ras_n;
		if (!rdy_line)
			n_rdy++;
		if (!zw_line)
			n_zw++;
		if (!rst) begin
			if (cas_q == 4'hF && cas_n != 4'hF) begin
				chk_bit("cas on edge", on_rise, pclk);
				chk_nib("cas lines", exp_cas, cas_n);
			end
			if (cas_q != 4'hF && cas_n == 4'hF)
				chk_bit("cas off edge", 1'b0, pclk);
			if (mux_q != mux)
				chk_bit("mux edge", on_rise, pclk);
			if (roe_q && !rdy_oe) begin
				chk_bit("ready off edge", 1'b1, pclk);
				chk_bit("ready driven high", 1'b1, ro_q);
			end
			if (zoe_q && !zw_oe)
				chk_bit("zw off edge", 1'b1, pclk);
			// Row strobes only ever move on the falling edge
			if (ras_q != ras_n) begin
				chk_bit("row edge", 1'b0, pclk);
				chk_bit("row copies", 1'b1, &ras_n | ~|ras_n);
			end
		end
	end

	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int i;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		avw <= w;
		avr <= ~w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wrq === 1'b0)
				break;
		end
		rd = rdata;
		avr <= 1'b0;
		avw <= 1'b0;
		if (i == 20) begin
			n_errors++;
			conclude();
		end
	endtask

	task automatic start(input logic [4:0] straps, input logic r,
			input logic [3:0] c);
		rst <= 1'b1;
		{page_n, grp, rwt, wwt, hold} <= straps;
		on_rise <= r;
		exp_cas <= c;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask

	// Strobe goes low while pclk is high, so it meets setup at the fall
	task automatic mem(input logic is_rd, input logic [14:0] pg,
			input logic er, input logic ez);
		int r0, z0, i;
		r0 = n_rdy;
		z0 = n_zw;
		for (i = 0; i < 40 && !(pclk === 1'b1 && pclk_q === 1'b0); i++)
			@(posedge clk);
		if (i == 40) begin
			n_errors++;
			conclude();
		end
		page <= pg;
		rd_n <= ~is_rd;
		wr_n <= is_rd;
		repeat (64) @(posedge clk);
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (64) @(posedge clk);
		chk_bit("ready pulled low", er, n_rdy != r0);
		chk_bit("zero-wait pulled low", ez, n_zw != z0);
	endtask

	initial begin
		start(5'b01110, 1'b1, 4'hC);
		bus(1'b0, pmd_pkg::CTRL_OFS, 32'h0000_0000);
		chk_word("ctrl reset", 32'h0000_0001, rd);
		bus(1'b0, 8'h0C, 32'h0000_0000);
		chk_word("unmapped", 32'h0000_0000, rd);
		mem(1'b1, 15'h0001, 1'b1, 1'b0);
		mem(1'b1, 15'h0001, 1'b0, 1'b1);
		mem(1'b0, 15'h0001, 1'b1, 1'b0);
		mem(1'b1, 15'h0002, 1'b1, 1'b0);
		bus(1'b1, pmd_pkg::CTRL_OFS, 32'h0000_0003);
		mem(1'b1, 15'h0002, 1'b1, 1'b0);
		bus(1'b0, pmd_pkg::HITS_OFS, 32'h0000_0000);
		chk_word("hit count", 32'h0000_0001, rd);
		// Disabled: row closes on the next fall and strobes are ignored
		on_rise <= 1'b0;
		bus(1'b1, pmd_pkg::CTRL_OFS, 32'h0000_0000);
		mem(1'b1, 15'h0002, 1'b0, 1'b0);
		chk_bit("row closed", 1'b1, ras_n[0]);
		chk_bit("mux closed", 1'b0, mux);
		chk_nib("cas idle", 4'hF, cas_n);
		start(5'b10000, 1'b0, 4'hC);
		mem(1'b1, 15'h0003, 1'b0, 1'b0);
		mem(1'b0, 15'h0003, 1'b0, 1'b0);
		start(5'b10110, 1'b1, 4'hC);
		mem(1'b1, 15'h0004, 1'b0, 1'b0);
		start(5'b10011, 1'b0, 4'hD);
		mem(1'b1, 15'h0005, 1'b0, 1'b0);
		conclude();
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule
